// ==== core/rom_protection_verify.sv ====
// ROM protection and production verify sequencer
`timescale 1ns/1ps
module rom_protection_verify
  import rom_verify_pkg::*;
#(
  parameter logic PROTECTED = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Strap inputs, sampled while reset is held
  input wire strap_pins_t strap_in,
  // Port 1 / port 2 address from tester
  input wire logic [7:0] port1_in,
  input wire logic [5:0] port2_in,
  // Port 0 data pin
  input wire logic [ROM_DATA_W-1:0] port0_in,
  output logic [ROM_DATA_W-1:0] port0_out,
  output logic port0_oe,
  // Strobe outputs
  output logic address_latch_strobe_out,
  output logic program_store_strobe_out,
  // Verify result
  output logic verify_result_pin,
  output logic verify_done,
  // CPU code read port
  input wire code_read_t code_read,
  output logic [ROM_DATA_W-1:0] code_read_data,
  output logic code_read_ack
);

  // ****************************************
  // State and registers
  // ****************************************
  verify_state_t state_reg, state_next;
  strap_pins_t strap_reg;
  logic [ROM_ADDR_W-1:0] ptr_reg, ptr_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] group_reg, group_next;
  logic err_reg, err_next;
  logic result_reg, result_next;
  logic ale_reg, ale_next;
  logic pss_reg;
  logic [ROM_DATA_W-1:0] p0_reg, p0_next;
  logic p0oe_reg, p0oe_next;
  logic [READ_DELAY_CYC-1:0] rd_pipe_reg;
  logic cr_pend_reg, cr_inval_reg;
  logic [ROM_DATA_W-1:0] crd_reg;
  logic cra_reg;

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic logic strap_is(input strap_pins_t s, input strap_pins_t pat);
    return s == pat;
  endfunction

  wire logic sel_unprot = strap_is(strap_reg, STRAP_UNPROT) && !PROTECTED;
  wire logic sel_prot = strap_is(strap_reg, STRAP_PROT) && PROTECTED;
  wire logic in_prot = state_reg == ST_PROT;
  wire logic in_unprot = state_reg == ST_UNPROT;

  // ****************************************
  // ROM read address mux
  // ****************************************
  wire logic [ROM_ADDR_W-1:0] tester_addr = {port2_in, port1_in};
  wire logic [ROM_ADDR_W-1:0] rom_addr = in_unprot ? tester_addr :
                                         in_prot ? ptr_reg : code_read.addr;
  logic [ROM_DATA_W-1:0] rom_data;

  rom_store u_rom (
    .sys_clk(sys_clk),
    .rd_addr(rom_addr),
    .rd_data(rom_data)
  );

  // ****************************************
  // Protected verify sequencing
  // ****************************************
  // Phase 0 raises strobe; port0 is sampled phase_reg==last, i.e. 2 phases later
  wire logic sample_now = in_prot && phase_reg == STROBE_LAST_PHASE;
  wire logic mismatch = port0_in != rom_data;
  wire logic group_end = sample_now && group_reg == GROUP_LAST;
  wire logic last_byte = sample_now && ptr_reg == ROM_LAST_ADDR;
  wire logic err_acc = err_reg | mismatch;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    phase_next = phase_reg;
    group_next = group_reg;
    err_next = err_reg;
    result_next = result_reg;
    ale_next = 1'b0;
    p0_next = p0_reg;
    p0oe_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // First cycle after reset release
        if (sel_prot) begin
          state_next = ST_PROT;
        end else if (sel_unprot) begin
          state_next = ST_UNPROT;
        end else begin
          state_next = ST_NORMAL;
        end
      end
      ST_UNPROT: begin
        p0_next = rom_data;
        // Drive only once the read pipe holds a byte of the tester's address
        p0oe_next = &rd_pipe_reg;
      end
      ST_PROT: begin
        // Port 0 stays input; no address leaves the device
        p0oe_next = 1'b0;
        phase_next = (phase_reg == STROBE_LAST_PHASE) ? 2'd0 : phase_reg + 2'd1;
        ale_next = (phase_next == 2'd0);
        if (sample_now) begin
          ptr_next = ptr_reg + 14'h0001;
          group_next = group_reg + 4'h1;
          err_next = err_acc;
          if (group_end) begin
            result_next = !err_acc;
            err_next = 1'b0;
          end
          if (last_byte) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
      end
      ST_NORMAL: begin
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Straps are caught while reset is held; async reset would forbid this
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      strap_reg <= strap_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      ptr_reg <= ROM_FIRST_ADDR;
      phase_reg <= 2'd0;
      group_reg <= 4'h0;
      err_reg <= 1'b0;
      result_reg <= RESULT_RESET;
      ale_reg <= 1'b0;
      pss_reg <= 1'b0;
      p0_reg <= PORT0_RESET;
      p0oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      phase_reg <= phase_next;
      group_reg <= group_next;
      err_reg <= err_next;
      result_reg <= result_next;
      ale_reg <= ale_next;
      pss_reg <= state_next == ST_DONE;
      p0_reg <= p0_next;
      p0oe_reg <= p0oe_next;
    end
  end

  // ****************************************
  // CPU code read path
  // ****************************************
  // Protection is a build parameter, so software cannot lift it
  wire logic cr_block = PROTECTED && code_read.from_external;
  wire logic cr_take = code_read.valid && state_reg == ST_NORMAL;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cr_pend_reg <= 1'b0;
      cr_inval_reg <= 1'b0;
      crd_reg <= INVALID_BYTE;
      cra_reg <= 1'b0;
      rd_pipe_reg <= '0;
    end else begin
      cr_pend_reg <= cr_take;
      cr_inval_reg <= cr_block;
      cra_reg <= cr_pend_reg;
      rd_pipe_reg <= {rd_pipe_reg[READ_DELAY_CYC-2:0], in_unprot};
      if (cr_pend_reg) begin
        crd_reg <= cr_inval_reg ? INVALID_BYTE : rom_data;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign port0_out = p0_reg;
  assign port0_oe = p0oe_reg;
  assign address_latch_strobe_out = ale_reg;
  assign program_store_strobe_out = pss_reg;
  assign verify_result_pin = result_reg;
  assign verify_done = pss_reg;
  assign code_read_data = crd_reg;
  assign code_read_ack = cra_reg;

endmodule // rom_protection_verify

// ==== core/rom_store.sv ====
// ROM array with registered read data
`timescale 1ns/1ps
module rom_store
  import rom_verify_pkg::*;
#(
  parameter logic [ROM_DATA_W-1:0] FILL = 8'h00
) (
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic [ROM_ADDR_W-1:0] rd_addr,
  output logic [ROM_DATA_W-1:0] rd_data
);

  logic [ROM_DATA_W-1:0] mem [0:(1<<ROM_ADDR_W)-1];

  // Content is a mask option; the default fill is an address pattern for simulation
  initial begin
    for (int i = 0; i < (1 << ROM_ADDR_W); i++) begin
      mem[i] = FILL ^ ROM_DATA_W'(i);
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule // rom_store

// ==== core/rom_verify_pkg.sv ====
// Package: constants and carrier types for the ROM protection and verify block
package rom_verify_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ROM_ADDR_W = 14;
  localparam int ROM_DATA_W = 8;
  localparam logic [ROM_ADDR_W-1:0] ROM_LAST_ADDR = 14'h3FFF;
  localparam logic [ROM_ADDR_W-1:0] ROM_FIRST_ADDR = 14'h0000;
  localparam logic [3:0] GROUP_LAST = 4'hF;

  // ****************************************
  // Timing (one clock phase taken as one sys_clk cycle)
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_PERIOD_CLP = 3;
  localparam int SAMPLE_DELAY_CLP = 3;
  localparam logic [1:0] STROBE_PERIOD_CYC = 2'(STROBE_PERIOD_CLP);
  localparam logic [1:0] STROBE_LAST_PHASE = 2'(STROBE_PERIOD_CLP - 1);
  // Unprotected read data latency, in cycles after the address is taken
  localparam int READ_DELAY_CYC = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RESULT_RESET = 1'b1;
  localparam logic [ROM_DATA_W-1:0] INVALID_BYTE = 8'hFF;
  localparam logic [ROM_DATA_W-1:0] PORT0_RESET = 8'hFF;

  // ****************************************
  // Strap pattern: levels seen during reset
  // ****************************************
  typedef struct packed {
    logic program_store_strobe;
    logic address_latch_strobe;
    logic external_access_select;
  } strap_pins_t;

  // Unprotected verify: strobe low, latch high, external access low
  localparam strap_pins_t STRAP_UNPROT = '{1'b0, 1'b1, 1'b0};
  // Protected verify: strobe low, latch low, external access high
  localparam strap_pins_t STRAP_PROT = '{1'b0, 1'b0, 1'b1};

  // CPU side code read request
  typedef struct packed {
    logic valid;
    logic from_external;
    logic [ROM_ADDR_W-1:0] addr;
  } code_read_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PROT    = 3'b001,
    ST_DONE    = 3'b011,
    ST_UNPROT  = 3'b010,
    ST_NORMAL  = 3'b100
  } verify_state_t;

endpackage

// ==== dv/rom_tester_model.sv ====
// Tester model: supplies expected bytes in ascending ROM order
`timescale 1ns/1ps
module rom_tester_model
  import rom_verify_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Device strobe and addresses whose byte is deliberately wrong
  input wire logic address_latch_strobe_out,
  input wire logic [ROM_ADDR_W-1:0] bad_a,
  input wire logic [ROM_ADDR_W-1:0] bad_b,
  // Expected byte
  output logic [ROM_DATA_W-1:0] port0_in
);
  logic [ROM_ADDR_W-1:0] idx_reg;
  logic corrupt;
  // Advance mid-cycle so the next byte is settled well before it is sampled
  always @(negedge sys_clk) begin
    if (!resetn) begin
      idx_reg <= ROM_FIRST_ADDR;
    end else if (address_latch_strobe_out) begin
      idx_reg <= idx_reg + 14'h0001;
    end
  end
  // Content matches the default fill, with one bit flipped where asked
  assign corrupt = (idx_reg == bad_a) || (idx_reg == bad_b);
  assign port0_in = idx_reg[7:0] ^ {7'h00, corrupt};
endmodule // rom_tester_model

// ==== dv/rom_verify_monitor.sv ====
// Checker for the ROM protection and verify block
`timescale 1ns/1ps
module rom_verify_monitor
  import rom_verify_pkg::*;
#(
  parameter logic PROTECTED = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Code read port
  input wire code_read_t code_read,
  input wire logic [ROM_DATA_W-1:0] code_read_data,
  input wire logic code_read_ack,
  // Pins
  input wire logic [ROM_DATA_W-1:0] port0_out,
  input wire logic port0_oe,
  input wire logic address_latch_strobe_out,
  input wire logic program_store_strobe_out,
  input wire logic verify_result_pin,
  input wire logic verify_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_strobe_gap;
    address_latch_strobe_out |=> !address_latch_strobe_out [*2];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too close");
  property p_strobe_period;
    address_latch_strobe_out |-> ##3 (address_latch_strobe_out || program_store_strobe_out);
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("strobe period");
  property p_result_static;
    $changed(verify_result_pin) |-> address_latch_strobe_out;
  endproperty
  a_result_static: assert property (p_result_static) else $error("result moved");
  property p_no_drive;
    address_latch_strobe_out |-> !port0_oe && port0_out == 8'hFF;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("port0 driven");
  property p_invalid;
    (code_read.valid && code_read.from_external && PROTECTED) ##2 code_read_ack
      |-> code_read_data == INVALID_BYTE;
  endproperty
  a_invalid: assert property (p_invalid) else $error("protected byte leaked");
  property p_ack_cause;
    code_read_ack |-> $past(code_read.valid, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without read");
  property p_done_sticky;
    program_store_strobe_out |=> program_store_strobe_out;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("end strobe dropped");
  property p_done_quiet;
    $past(program_store_strobe_out) |-> !address_latch_strobe_out;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("strobe after end");
  property p_done_pair;
    verify_done == program_store_strobe_out;
  endproperty
  a_done_pair: assert property (p_done_pair) else $error("done mismatch");
  c_strobe: cover property (address_latch_strobe_out);
  c_fail: cover property ($fell(verify_result_pin));
  c_end: cover property ($rose(program_store_strobe_out));
  c_ack: cover property (code_read_ack);
endmodule // rom_verify_monitor
bind rom_protection_verify rom_verify_monitor #(.PROTECTED(PROTECTED)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .code_read(code_read),
  .code_read_data(code_read_data), .code_read_ack(code_read_ack),
  .port0_out(port0_out), .port0_oe(port0_oe),
  .address_latch_strobe_out(address_latch_strobe_out),
  .program_store_strobe_out(program_store_strobe_out),
  .verify_result_pin(verify_result_pin), .verify_done(verify_done));

// ==== dv/tb.sv ====
// Testbench for the ROM protection and verify block
`timescale 1ns/1ps
module tb;
  import rom_verify_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  strap_pins_t strap_in = STRAP_PROT;
  logic [7:0] port1_in = 8'h00;
  logic [5:0] port2_in = 6'h00;
  logic [ROM_DATA_W-1:0] port0_in, port0_out, code_read_data;
  logic port0_oe, address_latch_strobe_out, program_store_strobe_out;
  logic verify_result_pin, verify_done, code_read_ack;
  code_read_t code_read = '0;
  logic [ROM_DATA_W-1:0] open_port0_out, open_rd_data;
  logic open_port0_oe, open_rd_ack;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  rom_protection_verify #(.PROTECTED(1'b1)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .strap_in(strap_in), .port1_in(port1_in), .port2_in(port2_in), .port0_in(port0_in),
    .port0_out(port0_out), .port0_oe(port0_oe),
    .address_latch_strobe_out(address_latch_strobe_out),
    .program_store_strobe_out(program_store_strobe_out),
    .verify_result_pin(verify_result_pin), .verify_done(verify_done),
    .code_read(code_read), .code_read_data(code_read_data), .code_read_ack(code_read_ack));
  // Unprotected build shares every input; it covers readout mode and open code reads
  rom_protection_verify #(.PROTECTED(1'b0)) dut_open (.sys_clk(sys_clk), .resetn(resetn),
    .strap_in(strap_in), .port1_in(port1_in), .port2_in(port2_in), .port0_in(port0_in),
    .port0_out(open_port0_out), .port0_oe(open_port0_oe), .address_latch_strobe_out(),
    .program_store_strobe_out(), .verify_result_pin(), .verify_done(),
    .code_read(code_read), .code_read_data(open_rd_data), .code_read_ack(open_rd_ack));
  rom_tester_model u_tester (.sys_clk(sys_clk), .resetn(resetn),
    .address_latch_strobe_out(address_latch_strobe_out), .bad_a(14'h0005),
    .bad_b(14'h3FFF), .port0_in(port0_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input strap_pins_t s);
    resetn = 1'b0;
    strap_in = s;
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
  endtask
  task automatic code_rd(input logic ext, input logic [13:0] a, input logic [7:0] exp);
    int n;
    code_read = '{1'b1, ext, a};
    @(negedge sys_clk);
    code_read.valid = 1'b0;
    for (n = 0; n < 6 && code_read_ack !== 1'b1; n++) @(negedge sys_clk);
    chk({7'h00, code_read_ack, code_read_data}, {8'h01, exp});
    // Default fill holds the low address byte; an open build never hides it
    chk({7'h00, open_rd_ack, open_rd_data}, {8'h01, a[7:0]});
  endtask
  task automatic test_normal();
    do_reset('{1'b1, 1'b1, 1'b1});
    repeat (20) @(negedge sys_clk);
    chk({14'h0, address_latch_strobe_out, program_store_strobe_out}, 16'h0000);
    code_rd(1'b1, 14'h0010, INVALID_BYTE);
    code_rd(1'b0, 14'h0023, 8'h23);
    code_rd(1'b1, 14'h3F5A, INVALID_BYTE);
    $display("test_normal done");
  endtask
  task automatic test_unprot();
    do_reset(STRAP_UNPROT);
    @(negedge sys_clk);
    {port2_in, port1_in} = 14'h2A5C;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, open_port0_oe, open_port0_out}, 16'h015C);
    {port2_in, port1_in} = 14'h1381;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, open_port0_oe, open_port0_out}, 16'h0181);
    chk({7'h00, port0_oe, port0_out}, 16'h00FF);
    $display("test_unprot done");
  endtask
  task automatic test_protected();
    int strobes;
    int n;
    strobes = 0;
    do_reset(STRAP_PROT);
    for (n = 0; n < 55000 && verify_done !== 1'b1; n++) begin
      @(negedge sys_clk);
      if (address_latch_strobe_out === 1'b1) begin
        strobes++;
        if (strobes == 1) chk(16'(n <= 5), 16'h0001);
        if (strobes > 1 && (strobes - 1) % 16 == 0) begin
          chk({15'h0, verify_result_pin}, 16'((strobes - 2) / 16 != 0));
        end
      end
    end
    @(negedge sys_clk);
    chk(16'(strobes), 16'h4000);
    chk({14'h0, program_store_strobe_out, verify_result_pin}, 16'h0002);
    $display("test_protected done");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    test_normal();
    test_unprot();
    test_protected();
    finish_test();
  end
endmodule // tb
